// ==== eep_consts.svh ====
// constants for the two-wire serial memory slave
// assumes a 25 MHz core clock; included by the package, eep_mem and eep_slave
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

// fixed device-type code in the upper control-byte nibble
`define EEP_DEV_CODE   4'ha
// array geometry: 256 words of 8 bits, 8-byte pages
`define EEP_ADDR_W     8
`define EEP_DATA_W     8
`define EEP_PAGE_W     3
// address bit that selects the protectable upper half
`define EEP_WP_BIT     7
// bit counter value of the ninth (acknowledge) clock, minus one
`define EEP_ACK_CNT    4'h8
`define EEP_LAST_BIT   4'h7
// longest self-timed write cycle, in microseconds
`define EEP_TWC_US     5000
// core clock rate in kilohertz
`define EEP_CLK_KHZ    25000

`endif

// ==== eep_pkg.sv ====
// types shared by the serial memory slave modules
// assumes eep_consts.svh is on the include path
`include "eep_consts.svh"

package eep_pkg;

  // protocol position of the slave between a start and a stop
  typedef enum logic [2:0] {
    ST_IDLE,   // not addressed, waiting for a start
    ST_CTRL,   // receiving the control byte
    ST_ADDR,   // receiving the word address
    ST_WDATA,  // receiving data bytes into the page buffer
    ST_RDATA   // transmitting data bytes
  } eep_state_t;

  // levels that cross into the core clock domain together
  typedef struct packed {
    logic wp;   // write-protect pin
    logic tgl;  // one toggle per link clock rising edge
    logic sda;  // data line
    logic scl;  // link clock line
  } eep_pins_t;

endpackage

// ==== eep_sync.sv ====
// two flip-flop level synchroniser for a packed bundle of signals
// assumes every input bit is a level that is stable for several cycles
module eep_sync import eep_pkg::*; #(
  parameter int W = 4
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta;  // first stage, read by the second stage only

  // both stages clear to zero; nothing else looks at the first stage
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// ==== eep_mem.sv ====
// storage array and page buffer of the serial memory
// assumes the caller orders buffer writes, commits and reads on i_core_clk
`include "eep_consts.svh"

module eep_mem import eep_pkg::*; #(
  parameter int AW = `EEP_ADDR_W,
  parameter int DW = `EEP_DATA_W,
  parameter int PW = `EEP_PAGE_W
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_reset_n,
  input  wire logic          i_buf_clr,
  input  wire logic          i_buf_we,
  input  wire logic [PW-1:0] i_buf_idx,
  input  wire logic [DW-1:0] i_buf_data,
  input  wire logic          i_commit,
  input  wire logic [AW-PW-1:0] i_page,
  input  wire logic          i_wp,
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [DW-1:0] o_rd_data
);

  localparam int PAGE_BYTES = 1 << PW;

  logic [DW-1:0]         arr [0:(1<<AW)-1];  // nonvolatile array
  logic [DW-1:0]         pbuf [0:PAGE_BYTES-1]; // page buffer data
  logic [PAGE_BYTES-1:0] pvalid;              // buffered byte present
  logic                  page_locked;         // upper half and protected

  // protection covers the upper half only; the lower half stays writable
  assign page_locked = i_wp & i_page[AW-PW-1];

  // byte-present flags: a later byte at the same slot simply overwrites
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pvalid <= '0;
    end else if (i_buf_clr || i_commit) begin
      pvalid <= '0;
    end else if (i_buf_we) begin
      pvalid[i_buf_idx] <= 1'b1;
    end
  end

  // buffer data needs no reset, pvalid guards its use
  always_ff @(posedge i_core_clk) begin
    if (i_buf_we) begin
      pbuf[i_buf_idx] <= i_buf_data;
    end
  end

  // commit all buffered bytes of the page at once; the busy time that
  // follows is only a timer, so contents change at the commit itself
  always_ff @(posedge i_core_clk) begin
    if (i_commit && !page_locked) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pvalid[i]) begin
          arr[{i_page, PW'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // registered read port; the pointer settles long before use
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= arr[i_rd_addr];
    end
  end

endmodule

// ==== eep_slave.sv ====
// two-wire serial slave access logic for a 256 x 8 nonvolatile memory
// assumes an external master drives scl and issues start and stop;
// sda is open drain with an outside pull-up, wp is tied or quasi-static
//
// Contract
// - answer only the 1010 device-type code
// - three block-select bits are don't care
// - control lsb one reads, zero writes
// - acknowledge matching control byte, then branch
// - write: second byte loads the address pointer
// - stop starts write cycle; no acks meanwhile
// - buffer up to eight bytes, commit at stop
// - low pointer bits increment, page bits fixed
// - page data wraps at page end
// - busy: no ack to write control byte
// - wp high protects upper half from writes
// - pointer stands one past last access
// - read: ack then shift out one byte
// - repeated start keeps pointer, drops the write
// - master ack requests the next sequential byte
// - pointer increments after each byte, whole array
// - release data line after master's final nack
// - write cycle ends within five milliseconds
`include "eep_consts.svh"

module eep_slave import eep_pkg::*; #(
  parameter int WC_CYCLES = `EEP_TWC_US * (`EEP_CLK_KHZ / 1000)
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset_n,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_wp,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  output logic      o_busy
);

  localparam int AW  = `EEP_ADDR_W;
  localparam int DW  = `EEP_DATA_W;
  localparam int PW  = `EEP_PAGE_W;
  localparam int WCW = $clog2(WC_CYCLES + 1);

  // link clock domain
  logic [DW:0]    link_sr;    // bits shifted in on rising scl
  logic           link_tgl;   // flips once per rising scl

  // core clock domain
  eep_pins_t      pins_raw;   // asynchronous levels
  eep_pins_t      pins_s;     // synchronised levels
  eep_pins_t      pins_d;     // previous synchronised levels
  eep_state_t     state;      // protocol position
  logic [3:0]     cnt;        // rising edges seen in the current byte
  logic           after_ack;  // ninth clock high has been seen
  logic           ack_pending;// slave acknowledges this byte
  logic           have_data;  // at least one data byte buffered
  logic [AW-1:0]  ptr;        // address pointer
  logic [AW-PW-1:0] page;     // page latched with the word address
  logic [DW-1:0]  tx_sr;      // outgoing byte, msb first
  logic [DW-1:0]  rd_data;    // array word at the pointer
  logic           busy;       // self-timed write cycle running
  logic [WCW-1:0] wc_cnt;     // write cycle elapsed cycles
  logic           oe;         // pull the data line low

  // decoded one-cycle events
  logic start_ev;   // sda falls while scl high
  logic stop_ev;    // sda rises while scl high
  logic fall_ev;    // scl falls
  logic bit_ev;     // a rising scl has been captured
  logic byte_done;  // eighth bit of a byte captured
  logic ack_ev;     // ninth (acknowledge) bit captured
  logic ctrl_ok;    // control byte addresses this device
  logic addr_ld;    // word address captured
  logic buf_we;     // data byte captured
  logic commit;     // stop ends a write with data
  logic nack_ev;    // master declined the next byte
  logic load_tx;    // fetch the next byte to transmit

  // the capture register runs on the link clock itself; its contents
  // hold still from one rising scl to the next, long enough for the
  // toggle to cross and the core to read the word
  always_ff @(posedge i_scl or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_sr  <= '0;
      link_tgl <= 1'b0;
    end else begin
      link_sr  <= {link_sr[DW-1:0], i_sda};
      link_tgl <= ~link_tgl;
    end
  end

  // bring pins and the capture toggle into the core domain
  assign pins_raw = '{wp: i_wp, tgl: link_tgl, sda: i_sda, scl: i_scl};

  eep_sync #(
    .W ($bits(eep_pins_t))
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_async    (pins_raw),
    .o_sync     (pins_s)
  );

  // one-cycle history for edge detection
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pins_d <= '0;
    end else begin
      pins_d <= pins_s;
    end
  end

  assign start_ev  = pins_d.scl & pins_s.scl & pins_d.sda & ~pins_s.sda;
  assign stop_ev   = pins_d.scl & pins_s.scl & ~pins_d.sda & pins_s.sda;
  assign fall_ev   = pins_d.scl & ~pins_s.scl;
  assign bit_ev    = (pins_s.tgl ^ pins_d.tgl) & (state != ST_IDLE);
  assign byte_done = bit_ev & (cnt == `EEP_LAST_BIT);
  assign ack_ev    = bit_ev & (cnt == `EEP_ACK_CNT);
  // only the type nibble is compared; block bits pass untested
  assign ctrl_ok   = (link_sr[DW-1:DW-4] == `EEP_DEV_CODE)
                     & ~busy;
  assign addr_ld   = byte_done & (state == ST_ADDR);
  assign buf_we    = byte_done & (state == ST_WDATA);
  assign commit    = stop_ev & (state == ST_WDATA) & have_data;
  // a high ninth bit from the master ends the read
  assign nack_ev   = ack_ev & (state == ST_RDATA) & ~ack_pending
                     & link_sr[0];
  assign load_tx   = fall_ev & after_ack & (state == ST_RDATA);

  // protocol sequencing; start and stop override any byte in flight
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state       <= ST_IDLE;
      cnt         <= '0;
      after_ack   <= 1'b0;
      ack_pending <= 1'b0;
      have_data   <= 1'b0;
    end else if (start_ev) begin
      // a repeated start drops any pending write but keeps the pointer
      state       <= ST_CTRL;
      cnt         <= '0;
      after_ack   <= 1'b0;
      ack_pending <= 1'b0;
      have_data   <= 1'b0;
    end else if (stop_ev) begin
      state       <= ST_IDLE;
      cnt         <= '0;
      after_ack   <= 1'b0;
      ack_pending <= 1'b0;
      have_data   <= 1'b0;
    end else if (ack_ev) begin
      // ninth clock: close the byte
      cnt         <= '0;
      after_ack   <= 1'b1;
      ack_pending <= 1'b0;
      if (nack_ev) begin
        state <= ST_IDLE;
      end
    end else if (bit_ev) begin
      cnt <= cnt + 4'h1;
      if (byte_done) begin
        case (state)
          ST_CTRL: begin
            if (ctrl_ok) begin
              ack_pending <= 1'b1;
              // lsb one reads, zero writes
              state <= link_sr[0] ? ST_RDATA : ST_ADDR;
            end else begin
              // not ours or busy: stay silent until the next start
              state <= ST_IDLE;
            end
          end
          ST_ADDR: begin
            ack_pending <= 1'b1;
            state       <= ST_WDATA;
          end
          ST_WDATA: begin
            // protected bytes are acknowledged like any other
            ack_pending <= 1'b1;
            have_data   <= 1'b1;
          end
          default: begin
            ack_pending <= 1'b0;
          end
        endcase
      end
    end else if (fall_ev) begin
      after_ack <= 1'b0;
    end
  end

  // address pointer: loaded by the word address, stepped per byte
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ptr  <= '0;
      page <= '0;
    end else if (addr_ld) begin
      ptr  <= link_sr[DW-1:0];
      page <= link_sr[DW-1:PW];
    end else if (buf_we) begin
      // only the in-page bits advance, so a long page write wraps
      ptr <= {ptr[AW-1:PW], ptr[PW-1:0] + PW'(1)};
    end else if (load_tx) begin
      // full-width step lets one read run through the whole array
      ptr <= ptr + AW'(1);
    end
  end

  // data line drive; changes only after scl has been seen low, which
  // keeps sda clear of false start and stop conditions
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      oe    <= 1'b0;
      tx_sr <= '0;
    end else if (start_ev || stop_ev) begin
      oe <= 1'b0;
    end else if (fall_ev) begin
      if (after_ack) begin
        if (state == ST_RDATA) begin
          // next byte goes out msb first
          tx_sr <= {rd_data[DW-2:0], 1'b0};
          oe    <= ~rd_data[DW-1];
        end else begin
          oe <= 1'b0;
        end
      end else if (cnt == `EEP_ACK_CNT) begin
        // hold low through the ninth clock high, or let go for the
        // master's acknowledge during reads
        oe <= ack_pending;
      end else if (state == ST_RDATA && cnt != 4'h0) begin
        oe    <= ~tx_sr[DW-1];
        tx_sr <= {tx_sr[DW-2:0], 1'b0};
      end
    end
  end

  // self-timed write cycle: a plain timer, the array commits at its start
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy   <= 1'b0;
      wc_cnt <= '0;
    end else if (commit) begin
      busy   <= 1'b1;
      wc_cnt <= '0;
    end else if (busy) begin
      wc_cnt <= wc_cnt + WCW'(1);
      if (wc_cnt == WCW'(WC_CYCLES - 1)) begin
        busy <= 1'b0;
      end
    end
  end

  eep_mem #(
    .AW (AW),
    .DW (DW),
    .PW (PW)
  ) u_mem (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_buf_clr  (addr_ld),
    .i_buf_we   (buf_we),
    .i_buf_idx  (ptr[PW-1:0]),
    .i_buf_data (link_sr[DW-1:0]),
    .i_commit   (commit),
    .i_page     (page),
    .i_wp       (pins_s.wp),
    .i_rd_addr  (ptr),
    .o_rd_data  (rd_data)
  );

  // open drain: the driven level is always low
  assign o_sda_out = 1'b0;
  assign o_sda_oe  = oe;
  assign o_busy    = busy;

  // checks on the core clock domain
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_ctrl_done;
    byte_done && state == ST_CTRL;
  endsequence

  sequence s_ctrl_match;
    s_ctrl_done ##0 (link_sr[7:4] == 4'ha) ##0 !busy;
  endsequence

  AST_CTRL_MISMATCH: assert property (
    s_ctrl_done ##0 (link_sr[7:4] != 4'ha) |=> state == ST_IDLE)
    else $error("foreign control code was answered");

  AST_CTRL_ACK: assert property (
    s_ctrl_match |=> ack_pending)
    else $error("matching control byte not acknowledged");

  AST_CTRL_DIR: assert property (
    s_ctrl_match |=> state == ($past(link_sr[0]) ? ST_RDATA : ST_ADDR))
    else $error("direction bit chose the wrong operation");

  AST_BUSY_SILENT: assert property (
    s_ctrl_done ##0 busy |=> !ack_pending && state == ST_IDLE)
    else $error("control byte acknowledged during write cycle");

  AST_ADDR_LOAD: assert property (
    addr_ld |=> ptr == $past(link_sr[7:0]) && state == ST_WDATA
            && ack_pending)
    else $error("word address not loaded into pointer");

  AST_PAGE_WRAP: assert property (
    buf_we |=> ptr[7:3] == $past(ptr[7:3])
           && ptr[2:0] == $past(ptr[2:0]) + 3'h1)
    else $error("page write pointer left its page");

  AST_COMMIT_STOP: assert property (
    commit |-> stop_ev ##1 busy [*8])
    else $error("commit without stop or busy not held");

  AST_BUSY_LEN: assert property (
    $fell(busy) |-> $past(wc_cnt) == WCW'(WC_CYCLES - 1))
    else $error("write cycle length wrong");

  AST_READ_STEP: assert property (
    load_tx |=> ptr == $past(ptr) + 8'h01)
    else $error("read did not advance the pointer");

  AST_NACK_RELEASE: assert property (
    nack_ev |=> state == ST_IDLE ##0 !o_sda_oe [*4])
    else $error("data line held after master nack");

  // ninth clock low phase of any byte, whether the slave receives or sends it
  sequence s_ack_slot;
    fall_ev && !after_ack && cnt == `EEP_ACK_CNT && !start_ev && !stop_ev;
  endsequence

  // the slave's own acknowledge must be on the line before scl rises
  AST_ACK_DRIVE: assert property (
    s_ack_slot ##0 ack_pending |=> o_sda_oe)
    else $error("acknowledge not driven on the ninth clock");

  // any start reopens the control byte and forgets buffered data
  AST_START_CTRL: assert property (
    start_ev |=> state == ST_CTRL && cnt == 4'h0 && !have_data)
    else $error("start did not reopen the control byte");

  // a stop ends any transfer and lets the data line go
  AST_STOP_RELEASE: assert property (
    stop_ev |=> state == ST_IDLE && !o_sda_oe)
    else $error("stop did not end the transfer");

endmodule

// ==== eep_master.sv ====
// behavioural two-wire bus master facing the serial memory slave
// assumes the bench resolves the open-drain data line and feeds it back
module eep_master import eep_pkg::*; (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // half scl period in core cycles: the slave needs at least 15
  localparam int Q = 16;

  // the bus idles with both lines released and scl standing still
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end

  // every change lands just after a core clock edge
  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  // one clock pulse; data moves only while scl is low, sample at high end
  task automatic bit_io(input logic b, output logic s);
    wt(4);
    o_sda_oe = ~b;
    wt(Q);
    o_scl = 1'b1;
    wt(Q);
    s = i_sda;
    o_scl = 1'b0;
  endtask

  // start, or repeated start when scl is already low
  task automatic start();
    if (!o_scl) begin
      wt(4);
      o_sda_oe = 1'b0;
      wt(Q);
      o_scl = 1'b1;
      wt(Q);
    end
    o_sda_oe = 1'b1;
    wt(Q);
    o_scl = 1'b0;
  endtask

  // data rises while scl is high, then the bus is left free
  task automatic stop();
    wt(4);
    o_sda_oe = 1'b1;
    wt(Q);
    o_scl = 1'b1;
    wt(Q);
    o_sda_oe = 1'b0;
    wt(Q);
  endtask

  // byte out msb first, lsb of a control byte is the direction
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // byte in; a low ninth bit asks for the next address
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, s);
  endtask
endmodule

// ==== eep_slave_bench.sv ====
// self-checking bench for the serial memory slave
// assumes eep_master drives the bus; wire is a wired-and with a pull-up
module eep_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened self-timed write cycle; must outlast one polling byte
  localparam int WC = 600;

  logic        clk;       // core clock, 40 ns
  logic        rst_n;     // asynchronous reset, active low
  logic        wp;        // write-protect pin
  logic        scl;       // serial clock from the master
  logic        m_oe;      // master pulls data low
  logic        dut_oe;    // slave pulls data low
  logic        dut_out;   // slave drive level, always low
  logic        busy;      // self-timed write cycle running
  logic        a;         // acknowledge seen by the master
  logic [7:0]  d;         // byte read back
  logic [15:0] busy_run;  // length of the running busy stretch
  logic [15:0] busy_len;  // length of the last finished stretch
  int          err_count;
  int          num_checks;
  int          cyc;

  // released line floats to the pull-up level
  wire sda = (m_oe | dut_oe) ? 1'b0 : 1'b1;

  eep_slave #(.WC_CYCLES(WC)) DUT (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda),
    .i_wp(wp), .o_sda_out(dut_out), .o_sda_oe(dut_oe), .o_busy(busy));

  eep_master u_master (
    .i_core_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // measure busy stretches and guard the run against a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) busy_run <= busy_run + 16'h1;
    else if (busy_run != 16'h0) begin
      busy_len <= busy_run;
      busy_run <= 16'h0;
    end
    if (cyc == 90000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded wait for the write cycle to end
  task automatic wait_idle();
    u_master.wt(4);
    for (int i = 0; i < 4000 && busy !== 1'b0; i++) u_master.wt(1);
    chk(busy, 1'b0);
  endtask

  // expected page byte: ten bytes from offset 2 wrap inside the page
  function automatic logic [7:0] pg(input int s);
    int j;
    j = (s + 6) % 8;
    if (j + 8 <= 9) j = j + 8;
    return 8'h30 + j[7:0];
  endfunction

  task automatic bwrite(input logic [7:0] ad, input logic [7:0] v);
    logic a0, a1, a2;
    u_master.start();
    u_master.wbyte(8'ha0, a0);
    u_master.wbyte(ad, a1);
    u_master.wbyte(v, a2);
    u_master.stop();
    chk({a0, a1, a2}, 16'h7);
    wait_idle();
  endtask

  task automatic rread(input logic [7:0] ad, output logic [7:0] v);
    logic a0;
    u_master.start();
    u_master.wbyte(8'ha0, a0);
    u_master.wbyte(ad, a0);
    u_master.start();
    u_master.wbyte(8'ha1, a0);
    chk(a0, 1'b1);
    u_master.rbyte(1'b0, v);
    chk(dut_oe, 1'b0);
    u_master.stop();
  endtask

  // every device-type code, then every block-select value
  task automatic t_select();
    for (int i = 0; i < 16; i++) begin
      u_master.start();
      u_master.wbyte({i[3:0], i[2:0], 1'b0}, a);
      chk(a, i == 10);
      u_master.stop();
    end
    for (int b = 0; b < 8; b++) begin
      u_master.start();
      u_master.wbyte({4'ha, b[2:0], 1'b0}, a);
      chk(a, 1'b1);
      u_master.stop();
      chk(busy, 1'b0);
    end
  endtask

  // ten bytes from offset 2 wrap over the page, then poll while busy
  task automatic t_page();
    u_master.start();
    u_master.wbyte(8'ha0, a);
    u_master.wbyte(8'h12, a);
    chk(a, 1'b1);
    for (int j = 0; j < 10; j++) begin
      u_master.wbyte(8'h30 + j[7:0], a);  // crosses on purpose
      chk(a, 1'b1);
    end
    chk(busy, 1'b0);
    u_master.stop();
    chk(busy, 1'b1);
    u_master.start();
    u_master.wbyte(8'ha0, a);  // polling right after the stop
    chk(a, 1'b0);
    u_master.stop();
    wait_idle();
    u_master.wt(2);
    chk(busy_len, 16'(WC));
    u_master.start();
    u_master.wbyte(8'ha0, a);
    chk(a, 1'b1);
    u_master.stop();
  endtask

  // random read of offset 0, then current-address sequential read
  task automatic t_read();
    rread(8'h10, d);
    chk(d, pg(0));
    u_master.wt(4);
    chk(busy, 1'b0);  // abandoned write commits nothing
    u_master.start();
    u_master.wbyte(8'ha1, a);
    chk(a, 1'b1);
    for (int k = 1; k < 8; k++) begin
      u_master.rbyte(k != 7, d);
      chk(d, pg(k));
    end
    chk(dut_oe, 1'b0);
    u_master.stop();
  endtask

  // protected upper half keeps its data, lower half still writable
  task automatic t_wp();
    bwrite(8'h90, 8'h11);
    @(posedge clk);
    #1;
    wp = 1'b1;
    u_master.wt(8);
    bwrite(8'h90, 8'h5a);
    bwrite(8'h20, 8'ha5);
    rread(8'h90, d);
    chk(d, 8'h11);
    rread(8'h20, d);
    chk(d, 8'ha5);
    @(posedge clk);
    #1;
    wp = 1'b0;
  endtask

  // reset for 12 cycles, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    cyc = 0;
    busy_run = 16'h0;
    busy_len = 16'h0;
    err_count = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    u_master.wt(6);
    chk({dut_oe, busy, dut_out}, 16'h0);
    t_select();
    t_page();
    t_read();
    t_wp();
    finish_test();
  end
endmodule
